// ==== hw/line_state_filter.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "usb_line_flag_map.svh"

module line_state_filter
   import usb_line_flag_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [1:0] lineStatePin,
   input wire logic [3:0] filterLog2,
   output logic [1:0] lineStateFilt
);

   // ****************************************
   // three-stage synchroniser
   // ****************************************
   logic [1:0] sync1;
   logic [1:0] sync2;
   logic [1:0] sync3;
   logic [1:0] next_sync1;
   logic [1:0] next_sync2;
   logic [1:0] next_sync3;

   always_comb begin
      next_sync1 = lineStatePin;
      next_sync2 = sync1;
      next_sync3 = sync2;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sync1 <= 2'h0;
         sync2 <= 2'h0;
         sync3 <= 2'h0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         sync3 <= next_sync3;
      end
   end

   // ****************************************
   // stability counter
   // ****************************************
   logic [`FILTER_CNT_WIDTH-1:0] count;
   logic [`FILTER_CNT_WIDTH-1:0] next_count;
   logic [`FILTER_CNT_WIDTH-1:0] limit;
   logic [1:0] next_lineStateFilt;

   // a new state must hold for 2**n clocks before it is passed on
   always_comb begin
      limit = (`FILTER_CNT_WIDTH'(1) << filterLog2) - `FILTER_CNT_WIDTH'(1);
      next_count = count;
      next_lineStateFilt = lineStateFilt;
      if (sync2 != sync3 || sync3 == lineStateFilt) begin
         next_count = '0; // glitch or no change: restart
      end else if (count >= limit) begin
         next_lineStateFilt = sync3;
         next_count = '0;
      end else begin
         next_count = count + `FILTER_CNT_WIDTH'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
         lineStateFilt <= 2'h0;
      end else begin
         count <= next_count;
         lineStateFilt <= next_lineStateFilt;
      end
   end

endmodule

`default_nettype wire

// ==== hw/usb_line_flag_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "usb_line_flag_map.svh"

module usb_line_flag_monitor
   import usb_line_flag_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   // peripheral register access, 32-bit words
   input wire regReq_t regReq,
   output logic [31:0] regRdata,
   output logic regRvalid,
   // transceiver and packet engine
   input wire logic [1:0] lineStatePin,
   input wire logic rxActivePin,
   input wire logic rxErrorPin,
   input wire token_t token,
   input wire logic [6:0] deviceAddr,
   input wire logic packetStart,
   input wire logic dataCrc16Fail,
   input wire logic autoResumeSe0,
   input wire logic autoResumeK,
   // controls out
   output logic pulldownDisable,
   output logic autoResumeEnable,
   output logic [2:0] transceiverConfig,
   output logic [1:0] lineStateFilt
);

   // ****************************************
   // line state filter
   // ****************************************
   logic [31:0] tctrl;

   line_state_filter filterInst (
      .core_clk(core_clk),
      .rstn(rstn),
      .lineStatePin(lineStatePin),
      .filterLog2(tctrl[`TC_FILTER_HI:`TC_FILTER_LO]),
      .lineStateFilt(lineStateFilt)
   );

   // ****************************************
   // rx level synchronisers
   // ****************************************
   logic [1:0] rxSync1;
   logic [1:0] rxSync2;
   logic [1:0] rxSync3;
   logic [1:0] rxLevel;
   logic [1:0] next_rxSync1;
   logic [1:0] next_rxSync2;
   logic [1:0] next_rxSync3;
   logic [1:0] next_rxLevel;

   // level taken only once stages two and three agree
   always_comb begin
      next_rxSync1 = {rxActivePin, rxErrorPin};
      next_rxSync2 = rxSync1;
      next_rxSync3 = rxSync2;
      next_rxLevel = rxLevel;
      if (rxSync2 == rxSync3) begin
         next_rxLevel = rxSync3;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rxSync1 <= 2'h0;
         rxSync2 <= 2'h0;
         rxSync3 <= 2'h0;
         rxLevel <= 2'h0;
      end else begin
         rxSync1 <= next_rxSync1;
         rxSync2 <= next_rxSync2;
         rxSync3 <= next_rxSync3;
         rxLevel <= next_rxLevel;
      end
   end

   // ****************************************
   // flag sources
   // ****************************************
   symbol_t sym;
   logic [`FLG_WIDTH-1:0] setEvent;
   logic tokenGood;

   always_comb begin
      sym = decodeSymbol(lineStateFilt);
      tokenGood = token.valid && token.crc5Ok && token.pidOk
         && (token.addr == deviceAddr);
      setEvent = '0;
      setEvent[`FLG_TOKEN] = tokenGood;
      setEvent[`FLG_SE0] = sym.se0;
      setEvent[`FLG_K] = sym.k;
      setEvent[`FLG_J] = sym.j;
      setEvent[`FLG_CRC16] = dataCrc16Fail;
      setEvent[`FLG_RXACTIVE] = rxLevel[1];
      setEvent[`FLG_RXERROR] = rxLevel[0];
   end

   // ****************************************
   // register decode
   // ****************************************
   logic wrFlags;
   logic wrPersist;
   logic wrTctrl;
   logic addrKnown;

   always_comb begin
      wrFlags = 1'b0;
      wrPersist = 1'b0;
      wrTctrl = 1'b0;
      addrKnown = 1'b1;
      if (regReq.addr == `OFS_LINE_SIGNAL_FLAGS) begin
         wrFlags = regReq.wr;
      end else if (regReq.addr == `OFS_FLAG_PERSISTENCE_MASK) begin
         wrPersist = regReq.wr;
      end else if (regReq.addr == `OFS_TRANSCEIVER_CONTROL) begin
         wrTctrl = regReq.wr;
      end else begin
         addrKnown = 1'b0;
      end
   end

   // ****************************************
   // flags and persistence mask
   // ****************************************
   logic [`FLG_WIDTH-1:0] flags;
   logic [`FLG_WIDTH-1:0] persist;
   logic [`FLG_WIDTH-1:0] next_flags;
   logic [`FLG_WIDTH-1:0] next_persist;
   logic [`FLG_WIDTH-1:0] levelBits;

   // rx bits are levels unless their persist bit is set; the others are latched events
   assign levelBits = `FLG_WIDTH'(7'h03);

   // per bit: clear first, then set, so a set in the clear cycle wins
   always_comb begin
      next_persist = persist;
      if (wrPersist) begin
         next_persist = regReq.wdata[`FLG_WIDTH-1:0];
      end
      next_flags = flags;
      for (int i = 0; i < `FLG_WIDTH; i++) begin
         if (persist[i]) begin
            if (wrFlags && regReq.wdata[i]) begin
               next_flags[i] = 1'b0;
            end
            if (setEvent[i]) begin
               next_flags[i] = 1'b1;
            end
         end else begin
            if (packetStart) begin
               next_flags[i] = 1'b0;
            end
            if (wrFlags && regReq.wdata[i]) begin
               next_flags[i] = 1'b0;
            end
            if (levelBits[i] && !packetStart) begin
               next_flags[i] = setEvent[i];
            end else if (setEvent[i]) begin
               next_flags[i] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flags <= `RST_FLAGS;
         persist <= `RST_PERSIST;
      end else begin
         flags <= next_flags;
         persist <= next_persist;
      end
   end

   // ****************************************
   // transceiver control
   // ****************************************
   logic [31:0] next_tctrl;
   logic [31:0] tctrlWmask;

   // writable fields only; reserved bits stay zero
   assign tctrlWmask = 32'h0004_3FF0;

   always_comb begin
      next_tctrl = tctrl;
      if (wrTctrl) begin
         // resume bits can only be cleared by software, never set
         next_tctrl = (regReq.wdata & tctrlWmask)
            & ~(32'h1 << `TC_RESUME_SE0) & ~(32'h1 << `TC_RESUME_K);
         next_tctrl[`TC_RESUME_SE0] = tctrl[`TC_RESUME_SE0]
            & regReq.wdata[`TC_RESUME_SE0];
         next_tctrl[`TC_RESUME_K] = tctrl[`TC_RESUME_K]
            & regReq.wdata[`TC_RESUME_K];
      end
      if (autoResumeSe0) begin
         next_tctrl[`TC_RESUME_SE0] = 1'b1;
      end
      if (autoResumeK) begin
         next_tctrl[`TC_RESUME_K] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tctrl <= `RST_TCTRL;
      end else begin
         tctrl <= next_tctrl;
      end
   end

   // ****************************************
   // registered control outputs
   // ****************************************
   logic next_pulldownDisable;
   logic next_autoResumeEnable;
   logic [2:0] next_transceiverConfig;

   // outputs are registered from next_tctrl, so they change on the same edge as the control register
   always_comb begin
      next_pulldownDisable = next_tctrl[`TC_PULLDOWN_OFF];
      next_autoResumeEnable = next_tctrl[`TC_AUTO_RESUME];
      next_transceiverConfig =
         next_tctrl[`TC_CONF_HI:`TC_CONF_LO];
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pulldownDisable <= 1'b0;
         autoResumeEnable <= 1'b0;
         transceiverConfig <= 3'h0;
      end else begin
         pulldownDisable <= next_pulldownDisable;
         autoResumeEnable <= next_autoResumeEnable;
         transceiverConfig <= next_transceiverConfig;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   logic [31:0] next_regRdata;
   logic next_regRvalid;

   // unmapped offsets read as zero; the read has no side effect
   always_comb begin
      next_regRvalid = regReq.rd;
      next_regRdata = 32'h0;
      if (regReq.rd && addrKnown) begin
         if (regReq.addr == `OFS_LINE_SIGNAL_FLAGS) begin
            next_regRdata = {25'h0, flags};
         end else if (regReq.addr == `OFS_FLAG_PERSISTENCE_MASK) begin
            next_regRdata = {25'h0, persist};
         end else begin
            next_regRdata = tctrl;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 32'h0;
         regRvalid <= 1'b0;
      end else begin
         regRdata <= next_regRdata;
         regRvalid <= next_regRvalid;
      end
   end

endmodule

`default_nettype wire

// ==== shared/usb_line_flag_map.svh ====
`ifndef USB_LINE_FLAG_MAP_SVH
`define USB_LINE_FLAG_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_LINE_SIGNAL_FLAGS 8'h1C
`define OFS_FLAG_PERSISTENCE_MASK 8'h20
`define OFS_TRANSCEIVER_CONTROL 8'h40

// ****************************************
// line_signal_flags fields
// ****************************************
`define FLG_TOKEN 6
`define FLG_SE0 5
`define FLG_K 4
`define FLG_J 3
`define FLG_CRC16 2
`define FLG_RXACTIVE 1
`define FLG_RXERROR 0
`define FLG_WIDTH 7

// ****************************************
// transceiver_control fields
// ****************************************
`define TC_PULLDOWN_OFF 18
`define TC_RESUME_SE0 13
`define TC_RESUME_K 12
`define TC_FILTER_HI 11
`define TC_FILTER_LO 8
`define TC_AUTO_RESUME 7
`define TC_CONF_HI 6
`define TC_CONF_LO 4

// ****************************************
// reset values
// ****************************************
`define RST_FLAGS 7'h00
`define RST_PERSIST 7'h00
`define RST_TCTRL 32'h0000_0000

// ****************************************
// timing: filter delay is 2**n clocks, n up to 15
// ****************************************
`define FILTER_CNT_WIDTH 16

`endif

// ==== shared/usb_line_flag_pkg.sv ====
`default_nettype none

package usb_line_flag_pkg;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } regReq_t;

   typedef struct packed {
      logic valid;
      logic crc5Ok;
      logic pidOk;
      logic [6:0] addr;
   } token_t;

   typedef struct packed {
      logic se0;
      logic j;
      logic k;
   } symbol_t;

   // utmi line state: 00 se0, 01 j, 10 k, 11 se1 (no flag)
   function automatic symbol_t decodeSymbol(input logic [1:0] ls);
      symbol_t s;
      s.se0 = (ls == 2'h0);
      s.j = (ls == 2'h1);
      s.k = (ls == 2'h2);
      return s;
   endfunction

endpackage

`default_nettype wire

// ==== verif/usb_line_flag_monitor_checker.sv ====
`timescale 1ns/10ps
`default_nettype none

module usb_line_flag_monitor_checker
   import usb_line_flag_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire regReq_t regReq,
   input wire logic [31:0] regRdata,
   input wire logic [1:0] lineStatePin,
   input wire logic autoResumeSe0,
   input wire logic autoResumeK,
   input wire logic packetStart,
   input wire logic pulldownDisable,
   input wire logic autoResumeEnable,
   input wire logic [2:0] transceiverConfig,
   input wire logic [1:0] lineStateFilt
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   // ****************
   // register strobes
   // ****************
   logic ctlWr, ctlRd, flgRd;
   assign ctlWr = regReq.wr && regReq.addr == 8'h40;
   assign ctlRd = regReq.rd && regReq.addr == 8'h40;
   assign flgRd = regReq.rd && regReq.addr == 8'h1C;
   // ****************
   // properties
   // ****************
   property p_pulldown;
      ctlWr |=> pulldownDisable == $past(regReq.wdata[18]);
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("pulldown");
   property p_config;
      ctlWr |=> transceiverConfig == $past(regReq.wdata[6:4])
         && autoResumeEnable == $past(regReq.wdata[7]);
   endproperty
   a_config: assert property (p_config) else $error("config");
   // outputs must not drift between writes
   property p_ctlHold;
      !ctlWr |=> $stable({pulldownDisable, autoResumeEnable,
         transceiverConfig});
   endproperty
   a_ctlHold: assert property (p_ctlHold) else $error("ctl hold");
   property p_se0Res;
      autoResumeSe0 ##1 !ctlWr ##1 ctlRd |=> regRdata[13];
   endproperty
   a_se0Res: assert property (p_se0Res) else $error("se0 resume");
   property p_kRes;
      autoResumeK ##1 !ctlWr ##1 ctlRd |=> regRdata[12];
   endproperty
   a_kRes: assert property (p_kRes) else $error("k resume");
   property p_resClr;
      ctlWr && !regReq.wdata[13] && !autoResumeSe0 ##1 !autoResumeSe0
         ##1 ctlRd |=> !regRdata[13];
   endproperty
   a_resClr: assert property (p_resClr) else $error("resume clr");
   // a filtered change needs the pin held at the new state before it;
   // depths 3 and 4 stay valid even for the shortest filter setting
   property p_filt;
      $changed(lineStateFilt) |-> $past(lineStatePin, 3) == lineStateFilt
         && $past(lineStatePin, 4) == lineStateFilt;
   endproperty
   a_filt: assert property (p_filt) else $error("filter");
   property p_lineJ;
      flgRd && $past(lineStateFilt) == 2'h1 |=> regRdata[3];
   endproperty
   a_lineJ: assert property (p_lineJ) else $error("j flag");
   c_ctlWr: cover property (ctlWr);
   c_pkt: cover property (packetStart);
   c_kRes: cover property (autoResumeK);
endmodule

bind usb_line_flag_monitor usb_line_flag_monitor_checker
   u_usb_line_flag_monitor_checker (
   .core_clk(core_clk), .rstn(rstn), .regReq(regReq),
   .regRdata(regRdata), .lineStatePin(lineStatePin),
   .autoResumeSe0(autoResumeSe0), .autoResumeK(autoResumeK),
   .packetStart(packetStart), .pulldownDisable(pulldownDisable),
   .autoResumeEnable(autoResumeEnable),
   .transceiverConfig(transceiverConfig), .lineStateFilt(lineStateFilt)
);

`default_nettype wire

// ==== verif/usb_line_flag_monitor_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module usb_line_flag_monitor_tb
   import usb_line_flag_pkg::*;
();
   // ****************
   // stimulus, model and design
   // ****************
   logic core_clk = 0;
   logic rstn = 0;
   regReq_t regReq = '0;
   token_t tok = '0;
   logic [3:0] ev = '0;
   logic [6:0] devAddr = 7'h00;
   logic [1:0] wantLs = 2'h1;
   logic wantAct = 0;
   logic wantErr = 0;
   logic [31:0] regRdata;
   logic regRvalid, pullOff, autoRes, actPin, errPin;
   logic [2:0] cfg;
   logic [1:0] filt, lsPin;
   logic [15:0] rnd = 16'h0008;
   logic [1:0] curLs = 2'h1;
   int err_count = 0;
   int check_count = 0;
   // model: se0 shows on the filter output right after reset
   int mFlag = 32'h20;
   int mMask = 0;
   int mCtrl = 0;
   int n = 0;

   initial forever #10 core_clk = ~core_clk;

   utmi_line_model u_utmi_line_model (
      .wantLs(wantLs), .wantAct(wantAct), .wantErr(wantErr),
      .lineStatePin(lsPin), .rxActivePin(actPin), .rxErrorPin(errPin)
   );
   usb_line_flag_monitor u_usb_line_flag_monitor (
      .core_clk(core_clk), .rstn(rstn), .regReq(regReq),
      .regRdata(regRdata), .regRvalid(regRvalid), .lineStatePin(lsPin),
      .rxActivePin(actPin), .rxErrorPin(errPin), .token(tok),
      .deviceAddr(devAddr), .packetStart(ev[0]), .dataCrc16Fail(ev[1]),
      .autoResumeSe0(ev[2]), .autoResumeK(ev[3]),
      .pulldownDisable(pullOff), .autoResumeEnable(autoRes),
      .transceiverConfig(cfg), .lineStateFilt(filt)
   );
   // ****************
   // tasks
   // ****************
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // levels are re-sampled each cycle, so apply them at every read
   function automatic void mSync();
      mFlag |= curLs == 2'h0 ? 32'h20 : curLs == 2'h1 ? 32'h08 :
         curLs == 2'h2 ? 32'h10 : 32'h00;
      for (int b = 0; b < 2; b++) begin
         if (!mMask[b]) mFlag[b] = 1'b0;
         mFlag[b] |= b ? wantAct : wantErr & wantAct;
      end
   endfunction
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge core_clk) regReq <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk) regReq <= '0;
      if (a == 8'h1C) mFlag &= ~d;
      if (a == 8'h20) mMask = d & 32'h7F;
      if (a == 8'h40) mCtrl = d & 32'h40FF0 | mCtrl & d & 32'h3000;
      #1 chk("ctl", {mCtrl[18], mCtrl[7], mCtrl[6:4]},
         {pullOff, autoRes, cfg});
   endtask
   task automatic rd(logic [7:0] a);
      int e;
      @(posedge core_clk) regReq <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge core_clk) regReq <= '0;
      mSync();
      e = a == 8'h1C ? mFlag : a == 8'h20 ? mMask : a == 8'h40 ? mCtrl : 0;
      #1 chk("rvalid", 1, regRvalid);
      chk($sformatf("reg %h", a), e, regRdata);
   endtask
   task automatic pulse(logic [3:0] p, token_t t);
      @(posedge core_clk) ev <= p;
      tok <= t;
      @(posedge core_clk) ev <= '0;
      tok <= '0;
      if (p[0]) mFlag &= mMask;
      // the line symbol still showing re-sets its flag in the clear cycle
      mSync();
      if (p[1]) mFlag |= 32'h4;
      if (p[2]) mCtrl |= 32'h2000;
      if (p[3]) mCtrl |= 32'h1000;
      if (t.valid && t.crc5Ok && t.pidOk && t.addr == devAddr)
         mFlag |= 32'h40;
   endtask
   task automatic setLs(logic [1:0] v);
      int c = 0;
      @(posedge core_clk) wantLs <= v;
      curLs = v;
      #1;
      while (filt !== v && c < 99) #20 c++;
      chk("filtDelay", 1, c > (1 << n) && c <= (1 << n) + 4);
      if (c >= 99) conclude();
   endtask
   // ****************
   // sequence
   // ****************
   initial begin
      token_t t;
      repeat (20) @(posedge core_clk);
      rstn <= 1;
      setLs(2'h1);
      rd(8'h40);
      rd(8'h20);
      rd(8'h1C);
      rd(8'h24);
      wr(8'h24, 32'hFFFFFFFF);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         wr(8'h40, {rnd, rnd});
         rd(8'h40);
      end
      wr(8'h40, 32'h40270);
      n = 2;
      pulse(4'h4, '0);
      rd(8'h40);
      pulse(4'h8, '0);
      rd(8'h40);
      wr(8'h40, 32'h43270);
      rd(8'h40);
      wr(8'h40, 32'h40270);
      rd(8'h40);
      for (int s = 0; s < 4; s++) begin
         setLs(s[1:0]);
         rd(8'h1C);
         pulse(4'h1, '0);
      end
      setLs(2'h1);
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         @(posedge core_clk) devAddr <= rnd[6:0];
         t = '{i[3], i[0], i[1], rnd[6:0] ^ {6'h0, !i[2]}};
         pulse({2'b0, i[2], 1'b1}, t);
         rd(8'h1C);
      end
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20);
      @(posedge core_clk) wantAct <= 1;
      repeat (8) @(posedge core_clk);
      mSync();
      @(posedge core_clk) wantAct <= 0;
      repeat (8) @(posedge core_clk);
      pulse(4'h1, '0);
      rd(8'h1C);
      wr(8'h1C, 32'h7E);
      rd(8'h1C);
      wr(8'h20, 32'h0);
      @(posedge core_clk) {wantAct, wantErr} <= 2'h3;
      repeat (8) @(posedge core_clk);
      rd(8'h1C);
      @(posedge core_clk) wantAct <= 0;
      repeat (8) @(posedge core_clk);
      rd(8'h1C);
      conclude();
   end
endmodule

`default_nettype wire

// ==== verif/utmi_line_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module utmi_line_model (
   input wire logic [1:0] wantLs,
   input wire logic wantAct,
   input wire logic wantErr,
   output logic [1:0] lineStatePin,
   output logic rxActivePin,
   output logic rxErrorPin
);
   // ****************
   // transceiver pins
   // ****************
   // 7 ns skew keeps pin edges off the core clock, as a real phy would
   assign #7 lineStatePin = wantLs;
   assign #7 rxActivePin = wantAct;
   // rx error only carries meaning inside a received packet
   assign #7 rxErrorPin = wantErr & wantAct;
endmodule

`default_nettype wire
